// ===== dv/dipms_partner.sv
// Purpose: activity detectors and data-enable source
// Assumes: driven from the bench through its tasks
// Notes: data enable idles low between pulses
`timescale 1ns/100ps
module dipms_partner (
  input wire logic clock,
  output dipms_pkg::dipms_act_t act_in,
  output logic data_enable_in
);
  import dipms_pkg::*;
  initial begin
    act_in = '0;
    data_enable_in = 1'b0;
  end
  task automatic set_act(input dipms_act_t a);
    @(posedge clock);
    act_in <= a;
  endtask
  // phases of 3 and 3 clocks so the input filter keeps every pulse
  task automatic de_pulses(input int n);
    repeat (n) begin
      @(posedge clock);
      data_enable_in <= 1'b1;
      repeat (3) @(posedge clock);
      data_enable_in <= 1'b0;
      repeat (2) @(posedge clock);
    end
  endtask
endmodule

// ===== dv/dipms_props.sv
// Purpose: port checks for the interface power mode selector
// Assumes: one clock, async active-low reset; only whole-word writes are checked
// Notes: pwr_en codes: seek 9D, digital CF, analog B7, off 80
`timescale 1ns/100ps
module dipms_props (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire dipms_pkg::dipms_pwr_t pwr_en,
  input wire logic out_sel_analog,
  input wire logic out_sel_digital,
  input wire logic sync_detect_out
);
  import dipms_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence ctrl_addr_s;
    clk_en && hsel && hready && htrans[1] && hwrite && haddr == 32'h48
      && hsize == DIPMS_HSIZE_WORD;
  endsequence
  sequence pwr_off_s;
    clk_en && hwdata[0] == 1'b0;
  endsequence
  one_sel_a: assert property (!(out_sel_analog && out_sel_digital))
    else $error("both interfaces drive the outputs");
  legal_pwr_a: assert property (
    pwr_en inside {8'h9D, 8'hCF, 8'hB7, 8'h80})
    else $error("power enables in no known mode");
  dig_pwr_a: assert property (out_sel_digital |-> pwr_en == 8'hCF)
    else $error("digital mode power set wrong");
  ana_pwr_a: assert property (out_sel_analog |-> pwr_en == 8'hB7)
    else $error("analog mode power set wrong");
  seek_quiet_a: assert property (pwr_en == 8'h9D |->
    !sync_detect_out && !out_sel_analog && !out_sel_digital)
    else $error("seek mode drives selects or sync");
  off_sel_a: assert property (pwr_en == 8'h80 |->
    !out_sel_analog && !out_sel_digital)
    else $error("power-down keeps an interface selected");
  reset_seek_a: assert property ($rose(arst_n) |-> pwr_en == 8'h9D)
    else $error("reset release not in seek mode");
  pdown_wr_a: assert property (
    ctrl_addr_s ##1 pwr_off_s |=> pwr_en == 8'h80)
    else $error("power-down write not obeyed");
endmodule
bind dipms_top dipms_props dipms_props_i (
  .clock(clock),
  .arst_n(arst_n),
  .clk_en(clk_en),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsize(hsize),
  .hwdata(hwdata),
  .hready(hready),
  .pwr_en(pwr_en),
  .out_sel_analog(out_sel_analog),
  .out_sel_digital(out_sel_digital),
  .sync_detect_out(sync_detect_out)
);

// ===== dv/tb.sv
// Purpose: self-checking bench for the mode selector
// Assumes: short data-enable count of 4 pulses
// Notes: expected word is {pwr_en, sel digital, sel analog, sync}
`timescale 1ns/100ps
module tb;
  import dipms_pkg::*;
  logic clock, arst_n, clk_en, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic out_sel_analog, out_sel_digital, sync_detect_out, data_enable_in;
  dipms_act_t act_in;
  dipms_pwr_t pwr_en;
  int mismatches = 0;
  int total_checks = 0;
  // row: {hsync, vsync, green, dclk, select, override}
  logic [5:0] vin [9] = '{6'h00, 6'h04, 6'h20, 6'h10, 6'h08, 6'h0C,
    6'h0E, 6'h05, 6'h03};
  logic [10:0] vexp [9] = '{11'h4E8, 11'h67C, 11'h5BB, 11'h5BA, 11'h5BA,
    11'h5BA, 11'h67C, 11'h5BA, 11'h67C};
  assign hready = hreadyout;
  dipms_top #(.DE_PULSES(4)) dipms_top_i (.clock(clock), .arst_n(arst_n),
    .clk_en(clk_en), .act_in(act_in), .data_enable_in(data_enable_in),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pwr_en(pwr_en), .out_sel_analog(out_sel_analog),
    .out_sel_digital(out_sel_digital), .sync_detect_out(sync_detect_out));
  dipms_partner dipms_partner_i (.clock(clock), .act_in(act_in),
    .data_enable_in(data_enable_in));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
    chk("hresp", {31'h0, DIPMS_HRESP_OKAY}, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
  endtask
  // input path is 4 edges plus one for the outputs
  task automatic expect_out(input logic [10:0] e);
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk("pwr_en", {24'h0, e[10:3]}, {24'h0, pwr_en});
    chk("sel", {30'h0, e[2:1]}, {30'h0, out_sel_digital, out_sel_analog});
    chk("sync", {31'h0, e[0]}, {31'h0, sync_detect_out});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #800000;
    mismatches++;
    print_verdict();
  end
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = '0;
    hwrite = 1'b0;
    hsize = DIPMS_HSIZE_WORD;
    hwdata = '0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    expect_out(11'h4E8);
    xfer(32'h3C, 1'b0, '0, rd);
    chk("unmapped", 32'h0, rd);
    xfer(32'h48, 1'b0, '0, rd);
    chk("ctrl", 32'h1, rd);
    for (int i = 0; i < 9; i++) begin
      dipms_partner_i.set_act(vin[i][5:2]);
      xfer(32'h50, 1'b1, {30'h0, vin[i][1:0]}, rd);
      expect_out(vexp[i]);
      xfer(32'h44, 1'b0, '0, rd);
      chk("status", {24'h0, vin[i][5:2], 4'h0}, rd);
    end
    xfer(32'h48, 1'b1, 32'h0, rd);
    expect_out(11'h400);
    xfer(32'h48, 1'b1, 32'h1, rd);
    xfer(32'h50, 1'b1, 32'h0, rd);
    dipms_partner_i.set_act(4'h1);
    expect_out(11'h67C);
    dipms_partner_i.de_pulses(3);
    expect_out(11'h67C);
    dipms_partner_i.de_pulses(1);
    expect_out(11'h67D);
    xfer(32'h54, 1'b0, '0, rd);
    chk("state", 32'h0000_CF0E, rd);
    hsize <= 3'h0;
    xfer(32'h48, 1'b1, 32'h0, rd);
    hsize <= DIPMS_HSIZE_WORD;
    expect_out(11'h67D);
    xfer(32'h48, 1'b0, '0, rd);
    chk("ctrl kept", 32'h1, rd);
    print_verdict();
  end
endmodule

// ===== hw/dipms_pkg.sv
// Purpose: shared constants and types for the interface power mode selector
// Assumes: 32-bit AHB-Lite register access, one system clock
// Notes: register offsets are word indices, byte address = 4 * index
package dipms_pkg;

  // register word indices
  localparam logic [7:0] DIPMS_IDX_STATUS = 8'h11;
  localparam logic [7:0] DIPMS_IDX_CTRL = 8'h12;
  localparam logic [7:0] DIPMS_IDX_IFSEL = 8'h14;
  localparam logic [7:0] DIPMS_IDX_STATE = 8'h15;

  // status register fields
  localparam int DIPMS_ST_HSYNC_BIT = 7;
  localparam int DIPMS_ST_VSYNC_BIT = 6;
  localparam int DIPMS_ST_GREEN_BIT = 5;
  localparam int DIPMS_ST_DCLK_BIT = 4;

  // control register fields
  localparam int DIPMS_CTRL_PWR_N_BIT = 0;
  localparam logic DIPMS_CTRL_PWR_N_RST = 1'b1;

  // interface select register fields
  localparam int DIPMS_IFSEL_OVR_BIT = 0;
  localparam int DIPMS_IFSEL_SEL_BIT = 1;
  localparam logic DIPMS_OVR_RST = 1'b0;
  localparam logic DIPMS_SEL_RST = 1'b0;

  // state register fields
  localparam int DIPMS_STATE_ANA_BIT = 0;
  localparam int DIPMS_STATE_DIG_BIT = 1;
  localparam int DIPMS_STATE_DE_BIT = 2;
  localparam int DIPMS_STATE_SYNC_BIT = 3;
  localparam int DIPMS_STATE_PWR_LSB = 8;

  // data-enable pulses needed before the digital link counts as live
  localparam int DIPMS_DE_PULSES = 32;

  // AHB-Lite encodings
  localparam logic [2:0] DIPMS_HSIZE_WORD = 3'h2;
  localparam logic DIPMS_HRESP_OKAY = 1'b0;
  localparam int DIPMS_ADDR_LSB = 2;
  localparam int DIPMS_ADDR_MSB = 9;

  typedef enum logic [1:0] {
    DIPMS_MODE_SEEK,
    DIPMS_MODE_DIGITAL,
    DIPMS_MODE_ANALOG,
    DIPMS_MODE_PDOWN
  } dipms_mode_t;

  // activity detector results, raw from the detector circuits
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic green;
    logic dclk;
  } dipms_act_t;

  // power-domain enables, high means powered
  typedef struct packed {
    logic serial_bus;
    logic digital_if;
    logic analog_if;
    logic dclk_detect;
    logic analog_act_detect;
    logic green_sync_slicer;
    logic outputs;
    logic bandgap;
  } dipms_pwr_t;

endpackage

// ===== hw/dipms_sync3.sv
// Purpose: three-flop input synchroniser with agreement filter
// Assumes: inputs are asynchronous to clock
// Notes: output follows once the second and third stages agree
`timescale 1ns/100ps
module dipms_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  import dipms_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } dipms_sync_st_t;

  dipms_sync_st_t st_r;
  dipms_sync_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    // s1 feeds s2 only, to keep metastability out of the filter
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;

endmodule

// ===== hw/dipms_top.sv
// Purpose: picks the active input interface and drives the power enables
// Assumes: detector results arrive asynchronously; AHB-Lite register access
// Notes: all outputs are registered; zero-wait-state bus slave
//
// What this block does
// - only one interface drives shared outputs
// - unselected interface is powered down automatically
// - no activity anywhere powers down both interfaces
// - priority: power-down, then override, then detection
// - digital active keeps bandgap and hsync detector on
// - analog active keeps digital clock detector on
// - override set: select bit forces analog or digital
// - nothing detected: no interface, sync detect low
// - only digital detected: digital on, analog off
// - only analog detected: analog on, digital off
// - both detected: select bit arbitrates the choice
// - seek mode powers exactly the five listed items
// - digital mode powers the six listed items
// - analog mode powers the six listed items
// - control bit low forces absolute power-down
// - analog detect is OR of three sync bits
// - digital detect is the clock activity bit
// - sync detect is DE detect OR hsync detect
// - DE detected after 32 pulses, digital powered
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module dipms_top #(
  parameter int DE_PULSES = dipms_pkg::DIPMS_DE_PULSES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // activity detectors and data enable from the digital receiver
  input wire dipms_pkg::dipms_act_t act_in,
  input wire logic data_enable_in,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // power enables and output routing
  output dipms_pkg::dipms_pwr_t pwr_en,
  output logic out_sel_analog,
  output logic out_sel_digital,
  output logic sync_detect_out
);
  import dipms_pkg::*;

  localparam int CNT_W = $clog2(DE_PULSES + 1);
  localparam logic [CNT_W-1:0] CNT_DONE = CNT_W'(DE_PULSES);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  // reset power set is the seek set, kept constant for the reset arm
  localparam dipms_pwr_t PWR_RST = '{serial_bus: 1'b1, digital_if: 1'b0,
    analog_if: 1'b0, dclk_detect: 1'b1, analog_act_detect: 1'b1,
    green_sync_slicer: 1'b1, outputs: 1'b0, bandgap: 1'b1};

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_idx;
    logic pwr_n;
    logic ovr;
    logic sel;
    logic de_prev;
    logic [CNT_W-1:0] de_cnt;
    logic de_seen;
    dipms_mode_t mode;
    dipms_pwr_t pwr;
    logic sel_a;
    logic sel_d;
    logic sync_det;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } dipms_state_t;

  dipms_state_t st_r;
  dipms_state_t st_nxt;

  // synchronised detector levels: hsync, vsync, green, dclk, data enable
  logic [4:0] raw_in;
  logic [4:0] syn;
  logic hs_act;
  logic vs_act;
  logic gs_act;
  logic dclk_act;
  logic de_lvl;

  assign raw_in = {act_in.hsync, act_in.vsync, act_in.green, act_in.dclk,
                   data_enable_in};

  dipms_sync3 #(
    .WIDTH(5)
  ) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .d(raw_in),
    .q(syn)
  );

  assign hs_act = syn[4];
  assign vs_act = syn[3];
  assign gs_act = syn[2];
  assign dclk_act = syn[1];
  assign de_lvl = syn[0];

  // power set for each mode; every domain is spelt out in each arm so a
  // dropped enable shows as a gap here rather than a silent default
  function automatic dipms_pwr_t pwr_of(input dipms_mode_t m);
    dipms_pwr_t p;
    p = '0;
    unique case (m)
      DIPMS_MODE_SEEK: begin
        p.serial_bus = 1'b1;
        p.digital_if = 1'b0;
        p.analog_if = 1'b0;
        p.dclk_detect = 1'b1;
        p.analog_act_detect = 1'b1;
        p.green_sync_slicer = 1'b1;
        p.outputs = 1'b0;
        p.bandgap = 1'b1;
      end
      DIPMS_MODE_DIGITAL: begin
        p.serial_bus = 1'b1;
        p.digital_if = 1'b1;
        p.analog_if = 1'b0;
        p.dclk_detect = 1'b0;
        // hsync detection lives in the analog activity detector
        p.analog_act_detect = 1'b1;
        p.green_sync_slicer = 1'b1;
        p.outputs = 1'b1;
        p.bandgap = 1'b1;
      end
      DIPMS_MODE_ANALOG: begin
        p.serial_bus = 1'b1;
        p.digital_if = 1'b0;
        p.analog_if = 1'b1;
        p.dclk_detect = 1'b1;
        p.analog_act_detect = 1'b0;
        p.green_sync_slicer = 1'b1;
        p.outputs = 1'b1;
        p.bandgap = 1'b1;
      end
      DIPMS_MODE_PDOWN: begin
        // only the register path survives, so software can wake it
        p.serial_bus = 1'b1;
        p.digital_if = 1'b0;
        p.analog_if = 1'b0;
        p.dclk_detect = 1'b0;
        p.analog_act_detect = 1'b0;
        p.green_sync_slicer = 1'b0;
        p.outputs = 1'b0;
        p.bandgap = 1'b0;
      end
    endcase
    return p;
  endfunction

  // register read mux, from the values the current cycle will leave
  function automatic logic [31:0] read_of(input logic [7:0] idx,
                                          input dipms_state_t s);
    logic [31:0] v;
    v = '0;
    unique case (idx)
      DIPMS_IDX_STATUS: begin
        v[DIPMS_ST_HSYNC_BIT] = hs_act;
        v[DIPMS_ST_VSYNC_BIT] = vs_act;
        v[DIPMS_ST_GREEN_BIT] = gs_act;
        v[DIPMS_ST_DCLK_BIT] = dclk_act;
      end
      DIPMS_IDX_CTRL: begin
        v[DIPMS_CTRL_PWR_N_BIT] = s.pwr_n;
      end
      DIPMS_IDX_IFSEL: begin
        v[DIPMS_IFSEL_OVR_BIT] = s.ovr;
        v[DIPMS_IFSEL_SEL_BIT] = s.sel;
      end
      DIPMS_IDX_STATE: begin
        v[DIPMS_STATE_ANA_BIT] = s.sel_a;
        v[DIPMS_STATE_DIG_BIT] = s.sel_d;
        v[DIPMS_STATE_DE_BIT] = s.de_seen;
        v[DIPMS_STATE_SYNC_BIT] = s.sync_det;
        v[DIPMS_STATE_PWR_LSB +: $bits(dipms_pwr_t)] = s.pwr;
      end
      default: begin
        // unmapped words keep the zero set above
      end
    endcase
    return v;
  endfunction

  logic ana_det;
  logic dig_det;
  logic addr_ok;
  logic take;
  logic size_ok;
  logic wr_take;
  logic rd_take;
  logic addr_hi_ok;
  logic addr_al_ok;
  logic de_rise;
  logic [7:0] a_idx;

  assign ana_det = hs_act | vs_act | gs_act;
  assign dig_det = dclk_act;

  assign a_idx = haddr[DIPMS_ADDR_MSB:DIPMS_ADDR_LSB];
  assign addr_hi_ok = (haddr[31:DIPMS_ADDR_MSB+1] == '0);
  assign addr_al_ok = (haddr[DIPMS_ADDR_LSB-1:0] == '0);
  assign addr_ok = addr_hi_ok & addr_al_ok;
  assign take = hsel & hready & htrans[1];
  // only whole-word writes change a register; reads ignore the size
  assign size_ok = (hsize == DIPMS_HSIZE_WORD);
  assign wr_take = take & hwrite & addr_ok & size_ok;
  assign rd_take = take & ~hwrite & addr_ok;
  // de_prev idles low like the pin, so reset makes no false edge
  assign de_rise = de_lvl & ~st_r.de_prev;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ready = 1'b1;
    st_nxt.resp = DIPMS_HRESP_OKAY;

    // data phase of a write: only whole words change registers
    if (st_r.wr_pend) begin
      unique case (st_r.wr_idx)
        DIPMS_IDX_CTRL: begin
          st_nxt.pwr_n = hwdata[DIPMS_CTRL_PWR_N_BIT];
        end
        DIPMS_IDX_IFSEL: begin
          st_nxt.ovr = hwdata[DIPMS_IFSEL_OVR_BIT];
          st_nxt.sel = hwdata[DIPMS_IFSEL_SEL_BIT];
        end
        default: begin
          // status and state words are read-only
        end
      endcase
    end

    // address phase
    st_nxt.wr_pend = wr_take;
    st_nxt.wr_idx = a_idx;

    // mode evaluation
    if (!st_nxt.pwr_n) begin
      st_nxt.mode = DIPMS_MODE_PDOWN;
    end else if (st_nxt.ovr) begin
      if (st_nxt.sel) begin
        st_nxt.mode = DIPMS_MODE_DIGITAL;
      end else begin
        st_nxt.mode = DIPMS_MODE_ANALOG;
      end
    end else begin
      unique case ({ana_det, dig_det})
        2'b00: begin
          st_nxt.mode = DIPMS_MODE_SEEK;
        end
        2'b01: begin
          st_nxt.mode = DIPMS_MODE_DIGITAL;
        end
        2'b10: begin
          st_nxt.mode = DIPMS_MODE_ANALOG;
        end
        2'b11: begin
          if (st_nxt.sel) begin
            st_nxt.mode = DIPMS_MODE_DIGITAL;
          end else begin
            st_nxt.mode = DIPMS_MODE_ANALOG;
          end
        end
      endcase
    end

    st_nxt.pwr = pwr_of(st_nxt.mode);
    // one-hot or none, so the shared outputs never see two drivers
    st_nxt.sel_a = (st_nxt.mode == DIPMS_MODE_ANALOG);
    st_nxt.sel_d = (st_nxt.mode == DIPMS_MODE_DIGITAL);

    // data enable pulses only count while the receiver has power
    st_nxt.de_prev = de_lvl;
    if (!st_r.pwr.digital_if) begin
      st_nxt.de_cnt = '0;
      st_nxt.de_seen = 1'b0;
    end else begin
      // saturate so a long run of pulses cannot wrap the detect off
      if (de_rise && st_r.de_cnt != CNT_DONE) begin
        st_nxt.de_cnt = st_r.de_cnt + CNT_ONE;
      end
      st_nxt.de_seen = (st_nxt.de_cnt == CNT_DONE);
    end

    if (st_nxt.mode == DIPMS_MODE_SEEK) begin
      st_nxt.sync_det = 1'b0;
    end else begin
      st_nxt.sync_det = st_nxt.de_seen | hs_act;
    end

    // read data lands in the data phase; unmapped reads give zero
    if (rd_take) begin
      st_nxt.rdata = read_of(a_idx, st_nxt);
    end else begin
      st_nxt.rdata = '0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r.wr_pend <= 1'b0;
      st_r.wr_idx <= '0;
      st_r.pwr_n <= DIPMS_CTRL_PWR_N_RST;
      st_r.ovr <= DIPMS_OVR_RST;
      st_r.sel <= DIPMS_SEL_RST;
      st_r.de_prev <= 1'b0;
      st_r.de_cnt <= '0;
      st_r.de_seen <= 1'b0;
      st_r.mode <= DIPMS_MODE_SEEK;
      st_r.pwr <= PWR_RST;
      st_r.sel_a <= 1'b0;
      st_r.sel_d <= 1'b0;
      st_r.sync_det <= 1'b0;
      st_r.rdata <= '0;
      st_r.ready <= 1'b1;
      st_r.resp <= DIPMS_HRESP_OKAY;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // no logic between the state flops and the pins
  assign hreadyout = st_r.ready;
  assign hresp = st_r.resp;
  assign hrdata = st_r.rdata;
  assign pwr_en = st_r.pwr;
  assign out_sel_analog = st_r.sel_a;
  assign out_sel_digital = st_r.sel_d;
  assign sync_detect_out = st_r.sync_det;

endmodule
